/* logic/uvra_params.svh */
// constants for the usb vendor register access block
`ifndef UVRA_PARAMS_SVH
`define UVRA_PARAMS_SVH

// setup packet codes
`define UVRA_TYPE_VWRITE 8'h40
`define UVRA_CODE_VWRITE 8'h00
`define UVRA_TYPE_VREAD 8'hC0
`define UVRA_CODE_VREAD 8'h01
`define UVRA_TYPE_CLASS 8'h21
`define UVRA_CODE_BREAK 8'h23

// block numbers
`define UVRA_BLK_CHANNEL 8'h00
`define UVRA_BLK_FIFO 8'h04

// channel register offsets
`define UVRA_OFS_CHAN_ENABLE 8'h03
`define UVRA_OFS_DIV_LOW 8'h04
`define UVRA_OFS_DIV_MID 8'h05
`define UVRA_OFS_DIV_HIGH 8'h06
`define UVRA_OFS_TXMASK_LOW 8'h07
`define UVRA_OFS_TXMASK_HIGH 8'h08
`define UVRA_OFS_RXMASK_LOW 8'h09
`define UVRA_OFS_RXMASK_HIGH 8'h0A
`define UVRA_OFS_FRAME 8'h0B
`define UVRA_OFS_PACING 8'h0C
`define UVRA_OFS_RESUME 8'h10
`define UVRA_OFS_PAUSE 8'h11
`define UVRA_OFS_ERRORS 8'h13
`define UVRA_OFS_BREAK 8'h14
`define UVRA_OFS_RELEASE 8'h15
`define UVRA_OFS_PIN_MODE 8'h1A
`define UVRA_OFS_PIN_DIR 8'h1B
`define UVRA_OFS_PIN_SET 8'h1D
`define UVRA_OFS_PIN_CLR 8'h1E
`define UVRA_OFS_PIN_LEVEL 8'h1F

// fifo manager register offsets
`define UVRA_OFS_FIFO_GATE 8'h10
`define UVRA_OFS_RX_FLUSH 8'h18
`define UVRA_OFS_TX_FLUSH 8'h1C

// field positions and widths
`define UVRA_BIT_TX 0
`define UVRA_BIT_RX 1
`define UVRA_DIV_HIGH_W 3
`define UVRA_PACING_W 4
`define UVRA_RELEASE_W 4
`define UVRA_PIN_MODE_W 4
`define UVRA_PINS 6
`define UVRA_ERR_W 5

// reset values
`define UVRA_RST_BYTE 8'h00
`define UVRA_RST_WORD 16'h0000

`endif

/* logic/uvra_pkg.sv */
// types shared by the usb vendor register access block
package uvra_pkg;
    // state of the read stream engine
    typedef enum logic [1:0] {
        UVRA_ST_IDLE = 2'b00,
        UVRA_ST_LOAD = 2'b01,
        UVRA_ST_SEND = 2'b10
    } uvra_state_t;

    // decoded kind of a setup packet
    typedef enum logic [1:0] {
        UVRA_REQ_NONE = 2'b00,
        UVRA_REQ_WRITE = 2'b01,
        UVRA_REQ_READ = 2'b10,
        UVRA_REQ_BREAK = 2'b11
    } uvra_req_t;
endpackage : uvra_pkg

/* logic/uvra_rd_if.sv */
// link between register bank and read stream engine
`timescale 1ns/1ps
interface uvra_rd_if;
    logic start;
    logic [15:0] len;
    logic [7:0] first_addr;
    logic [7:0] blk;
    logic [7:0] cur_addr;
    logic [7:0] rd_byte;
    logic busy;

    modport bank (output start, len, first_addr, blk, rd_byte, input cur_addr, busy);
    modport stream (input start, len, first_addr, blk, rd_byte, output cur_addr, busy);
endinterface : uvra_rd_if

/* logic/uvra_stream.sv */
// read stream engine: hands out a run of register bytes
`timescale 1ns/1ps
`include "uvra_params.svh"
module uvra_stream
    import uvra_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    uvra_rd_if.stream rd,
    input wire logic i_rd_ready,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data
);
    uvra_state_t state_r, state_nxt;
    logic [15:0] left_r, left_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic valid_r, valid_nxt;
    logic [7:0] data_r, data_nxt;

    // one byte per load, wait for the data stage to take it
    always_comb begin
        state_nxt = state_r;
        left_nxt = left_r;
        addr_nxt = addr_r;
        valid_nxt = valid_r;
        data_nxt = data_r;
        case (state_r)
            UVRA_ST_IDLE: begin
                if (rd.start && (rd.len != 16'h0000)) begin
                    left_nxt = rd.len;
                    addr_nxt = rd.first_addr;
                    state_nxt = UVRA_ST_LOAD;
                end
            end
            UVRA_ST_LOAD: begin
                data_nxt = rd.rd_byte;
                valid_nxt = 1'b1;
                state_nxt = UVRA_ST_SEND;
            end
            UVRA_ST_SEND: begin
                if (i_rd_ready) begin
                    valid_nxt = 1'b0;
                    left_nxt = left_r - 16'h0001;
                    addr_nxt = addr_r + 8'h01; // consecutive registers
                    state_nxt = (left_r == 16'h0001) ? UVRA_ST_IDLE : UVRA_ST_LOAD;
                end
            end
            default: state_nxt = UVRA_ST_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= UVRA_ST_IDLE;
            left_r <= `UVRA_RST_WORD;
            addr_r <= `UVRA_RST_BYTE;
            valid_r <= 1'b0;
            data_r <= `UVRA_RST_BYTE;
        end else begin
            state_r <= state_nxt;
            left_r <= left_nxt;
            addr_r <= addr_nxt;
            valid_r <= valid_nxt;
            data_r <= data_nxt;
        end
    end

    assign rd.cur_addr = addr_r;
    assign rd.busy = (state_r != UVRA_ST_IDLE);
    assign o_rd_valid = valid_r;
    assign o_rd_data = data_r;
endmodule : uvra_stream

/* logic/uvra_bank.sv */
// register bank and setup request decoder of the usb to uart bridge
`timescale 1ns/1ps
`include "uvra_params.svh"
module uvra_bank
    import uvra_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    // decoded setup packet
    input wire logic i_setup_valid,
    input wire logic [7:0] i_req_type,
    input wire logic [7:0] i_req_code,
    input wire logic [15:0] i_value,
    input wire logic [15:0] i_index,
    input wire logic [15:0] i_length,
    output logic o_ack,
    output logic o_stall,
    // data stage of read requests
    input wire logic i_rd_ready,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data,
    // state reported by the uart
    input wire logic [`UVRA_ERR_W-1:0] i_line_errors,
    input wire logic [`UVRA_PINS-1:0] i_pin_levels,
    // configuration towards the uart
    output logic o_tx_enable,
    output logic o_rx_enable,
    output logic [18:0] o_baud_divisor,
    output logic [15:0] o_transmit_bit_mask,
    output logic [15:0] o_receive_bit_mask,
    output logic [7:0] o_frame_format,
    output logic [`UVRA_PACING_W-1:0] o_pacing_mode,
    output logic [7:0] o_resume_character,
    output logic [7:0] o_pause_character,
    output logic o_break_start,
    output logic [15:0] o_break_duration,
    output logic [`UVRA_RELEASE_W-1:0] o_release_delay,
    output logic [`UVRA_PIN_MODE_W-1:0] o_pin_mode,
    output logic [`UVRA_PINS-1:0] o_pin_direction,
    output logic [`UVRA_PINS-1:0] o_pin_output,
    output logic o_tx_fifo_on,
    output logic o_rx_fifo_on,
    output logic o_tx_fifo_flush,
    output logic o_rx_fifo_flush
);
    uvra_rd_if rd ();

    // classifies a setup packet
    function automatic uvra_req_t classify(input logic [7:0] rtype, input logic [7:0] code,
                                           input logic [15:0] idx, input logic [15:0] len);
        uvra_req_t kind;
        kind = UVRA_REQ_NONE;
        if (rtype == `UVRA_TYPE_VWRITE && code == `UVRA_CODE_VWRITE && len == 16'h0000) begin
            kind = UVRA_REQ_WRITE;
        end else if (rtype == `UVRA_TYPE_VREAD && code == `UVRA_CODE_VREAD) begin
            kind = UVRA_REQ_READ;
        end else if (rtype == `UVRA_TYPE_CLASS && code == `UVRA_CODE_BREAK && len == 16'h0000
                     && idx[15:3] == 13'h0000 && idx[0] == 1'b0) begin
            kind = UVRA_REQ_BREAK; // interfaces 0, 2, 4, 6
        end
        return kind;
    endfunction : classify

    uvra_req_t kind;
    logic wr_chan;
    logic wr_fifo;
    logic [7:0] wr_addr;
    logic [7:0] wr_val;

    // decode of the incoming request
    always_comb begin
        kind = i_setup_valid ? classify(i_req_type, i_req_code, i_index, i_length)
                             : UVRA_REQ_NONE;
        wr_addr = i_index[7:0];
        wr_val = i_value[7:0];
        wr_chan = (kind == UVRA_REQ_WRITE) && (i_index[15:8] == `UVRA_BLK_CHANNEL);
        wr_fifo = (kind == UVRA_REQ_WRITE) && (i_index[15:8] == `UVRA_BLK_FIFO);
    end

    // configuration state
    logic tx_en_r, tx_en_nxt;
    logic rx_en_r, rx_en_nxt;
    logic [18:0] div_r, div_nxt;
    logic [15:0] txm_r, txm_nxt;
    logic [15:0] rxm_r, rxm_nxt;
    logic [7:0] frame_r, frame_nxt;
    logic [`UVRA_PACING_W-1:0] pace_r, pace_nxt;
    logic [7:0] resume_r, resume_nxt;
    logic [7:0] pause_r, pause_nxt;
    logic brk_go_r, brk_go_nxt;
    logic [15:0] brk_r, brk_nxt;
    logic [`UVRA_RELEASE_W-1:0] rel_r, rel_nxt;
    logic [`UVRA_PIN_MODE_W-1:0] pmode_r, pmode_nxt;
    logic [`UVRA_PINS-1:0] pdir_r, pdir_nxt;
    logic [`UVRA_PINS-1:0] pout_r, pout_nxt;
    logic txf_on_r, txf_on_nxt;
    logic rxf_on_r, rxf_on_nxt;
    logic txf_fl_r, txf_fl_nxt;
    logic rxf_fl_r, rxf_fl_nxt;
    logic ack_r, ack_nxt;
    logic stall_r, stall_nxt;
    logic [7:0] rblk_r, rblk_nxt;

    // register writes, break requests and request answers
    always_comb begin
        tx_en_nxt = tx_en_r;
        rx_en_nxt = rx_en_r;
        div_nxt = div_r;
        txm_nxt = txm_r;
        rxm_nxt = rxm_r;
        frame_nxt = frame_r;
        pace_nxt = pace_r;
        resume_nxt = resume_r;
        pause_nxt = pause_r;
        brk_go_nxt = 1'b0;
        brk_nxt = brk_r;
        rel_nxt = rel_r;
        pmode_nxt = pmode_r;
        pdir_nxt = pdir_r;
        pout_nxt = pout_r;
        txf_on_nxt = txf_on_r;
        rxf_on_nxt = rxf_on_r;
        txf_fl_nxt = 1'b0;
        rxf_fl_nxt = 1'b0;
        ack_nxt = 1'b0;
        stall_nxt = 1'b0;
        rblk_nxt = rd.start ? i_index[15:8] : rblk_r; // block held for the whole run
        if (i_setup_valid) begin
            // a read still streaming refuses any new request
            if (kind == UVRA_REQ_NONE || rd.busy) begin
                stall_nxt = 1'b1;
            end else begin
                ack_nxt = 1'b1;
            end
        end
        if (!rd.busy) begin
            if (wr_chan) begin
                // channel set, unlisted offsets fall through
                if (wr_addr == `UVRA_OFS_CHAN_ENABLE) begin
                    tx_en_nxt = wr_val[`UVRA_BIT_TX];
                    rx_en_nxt = wr_val[`UVRA_BIT_RX];
                end else if (wr_addr == `UVRA_OFS_DIV_LOW) begin
                    div_nxt[7:0] = wr_val;
                end else if (wr_addr == `UVRA_OFS_DIV_MID) begin
                    div_nxt[15:8] = wr_val;
                end else if (wr_addr == `UVRA_OFS_DIV_HIGH) begin
                    div_nxt[18:16] = wr_val[`UVRA_DIV_HIGH_W-1:0];
                end else if (wr_addr == `UVRA_OFS_TXMASK_LOW) begin
                    txm_nxt[7:0] = wr_val;
                end else if (wr_addr == `UVRA_OFS_TXMASK_HIGH) begin
                    txm_nxt[15:8] = wr_val;
                end else if (wr_addr == `UVRA_OFS_RXMASK_LOW) begin
                    rxm_nxt[7:0] = wr_val;
                end else if (wr_addr == `UVRA_OFS_RXMASK_HIGH) begin
                    rxm_nxt[15:8] = wr_val;
                end else if (wr_addr == `UVRA_OFS_FRAME) begin
                    frame_nxt = wr_val;
                end else if (wr_addr == `UVRA_OFS_PACING) begin
                    pace_nxt = wr_val[`UVRA_PACING_W-1:0];
                end else if (wr_addr == `UVRA_OFS_RESUME) begin
                    resume_nxt = wr_val;
                end else if (wr_addr == `UVRA_OFS_PAUSE) begin
                    pause_nxt = wr_val;
                end else if (wr_addr == `UVRA_OFS_BREAK) begin
                    brk_nxt = {8'h00, wr_val};
                    brk_go_nxt = 1'b1;
                end else if (wr_addr == `UVRA_OFS_RELEASE) begin
                    rel_nxt = wr_val[`UVRA_RELEASE_W-1:0];
                end else if (wr_addr == `UVRA_OFS_PIN_MODE) begin
                    pmode_nxt = wr_val[`UVRA_PIN_MODE_W-1:0];
                end else if (wr_addr == `UVRA_OFS_PIN_DIR) begin
                    pdir_nxt = wr_val[`UVRA_PINS-1:0];
                end else if (wr_addr == `UVRA_OFS_PIN_SET) begin
                    pout_nxt = pout_r | wr_val[`UVRA_PINS-1:0];
                end else if (wr_addr == `UVRA_OFS_PIN_CLR) begin
                    pout_nxt = pout_r & ~wr_val[`UVRA_PINS-1:0];
                end
            end else if (wr_fifo) begin
                // fifo manager set
                if (wr_addr == `UVRA_OFS_FIFO_GATE) begin
                    txf_on_nxt = wr_val[`UVRA_BIT_TX];
                    rxf_on_nxt = wr_val[`UVRA_BIT_RX];
                end else if (wr_addr == `UVRA_OFS_RX_FLUSH) begin
                    rxf_fl_nxt = (wr_val != 8'h00);
                end else if (wr_addr == `UVRA_OFS_TX_FLUSH) begin
                    txf_fl_nxt = (wr_val != 8'h00);
                end
            end
            // other block numbers are accepted and change nothing
            if (kind == UVRA_REQ_BREAK) begin
                brk_nxt = i_value;
                brk_go_nxt = 1'b1;
            end
        end
    end

    // configuration registers
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx_en_r <= 1'b0;
            rx_en_r <= 1'b0;
            div_r <= 19'h00000;
            txm_r <= `UVRA_RST_WORD;
            rxm_r <= `UVRA_RST_WORD;
            frame_r <= `UVRA_RST_BYTE;
            pace_r <= '0;
            resume_r <= `UVRA_RST_BYTE;
            pause_r <= `UVRA_RST_BYTE;
            brk_go_r <= 1'b0;
            brk_r <= `UVRA_RST_WORD;
            rel_r <= '0;
            pmode_r <= '0;
            pdir_r <= '0;
            pout_r <= '0;
            txf_on_r <= 1'b0;
            rxf_on_r <= 1'b0;
            txf_fl_r <= 1'b0;
            rxf_fl_r <= 1'b0;
            ack_r <= 1'b0;
            stall_r <= 1'b0;
            rblk_r <= `UVRA_RST_BYTE;
        end else begin
            tx_en_r <= tx_en_nxt;
            rx_en_r <= rx_en_nxt;
            div_r <= div_nxt;
            txm_r <= txm_nxt;
            rxm_r <= rxm_nxt;
            frame_r <= frame_nxt;
            pace_r <= pace_nxt;
            resume_r <= resume_nxt;
            pause_r <= pause_nxt;
            brk_go_r <= brk_go_nxt;
            brk_r <= brk_nxt;
            rel_r <= rel_nxt;
            pmode_r <= pmode_nxt;
            pdir_r <= pdir_nxt;
            pout_r <= pout_nxt;
            txf_on_r <= txf_on_nxt;
            rxf_on_r <= rxf_on_nxt;
            txf_fl_r <= txf_fl_nxt;
            rxf_fl_r <= rxf_fl_nxt;
            ack_r <= ack_nxt;
            stall_r <= stall_nxt;
            rblk_r <= rblk_nxt;
        end
    end

    // read mux for the stream engine; flush registers read zero
    always_comb begin
        rd.rd_byte = 8'h00; // reserved addresses and blocks
        if (rd.blk == `UVRA_BLK_CHANNEL) begin
            if (rd.cur_addr == `UVRA_OFS_CHAN_ENABLE) begin
                rd.rd_byte = {6'h00, rx_en_r, tx_en_r};
            end else if (rd.cur_addr == `UVRA_OFS_DIV_LOW) begin
                rd.rd_byte = div_r[7:0];
            end else if (rd.cur_addr == `UVRA_OFS_DIV_MID) begin
                rd.rd_byte = div_r[15:8];
            end else if (rd.cur_addr == `UVRA_OFS_DIV_HIGH) begin
                rd.rd_byte = {5'h00, div_r[18:16]};
            end else if (rd.cur_addr == `UVRA_OFS_TXMASK_LOW) begin
                rd.rd_byte = txm_r[7:0];
            end else if (rd.cur_addr == `UVRA_OFS_TXMASK_HIGH) begin
                rd.rd_byte = txm_r[15:8];
            end else if (rd.cur_addr == `UVRA_OFS_RXMASK_LOW) begin
                rd.rd_byte = rxm_r[7:0];
            end else if (rd.cur_addr == `UVRA_OFS_RXMASK_HIGH) begin
                rd.rd_byte = rxm_r[15:8];
            end else if (rd.cur_addr == `UVRA_OFS_FRAME) begin
                rd.rd_byte = frame_r;
            end else if (rd.cur_addr == `UVRA_OFS_PACING) begin
                rd.rd_byte = {4'h0, pace_r};
            end else if (rd.cur_addr == `UVRA_OFS_RESUME) begin
                rd.rd_byte = resume_r;
            end else if (rd.cur_addr == `UVRA_OFS_PAUSE) begin
                rd.rd_byte = pause_r;
            end else if (rd.cur_addr == `UVRA_OFS_ERRORS) begin
                rd.rd_byte = {i_line_errors, 3'h0};
            end else if (rd.cur_addr == `UVRA_OFS_BREAK) begin
                rd.rd_byte = brk_r[7:0];
            end else if (rd.cur_addr == `UVRA_OFS_RELEASE) begin
                rd.rd_byte = {4'h0, rel_r};
            end else if (rd.cur_addr == `UVRA_OFS_PIN_MODE) begin
                rd.rd_byte = {4'h0, pmode_r};
            end else if (rd.cur_addr == `UVRA_OFS_PIN_DIR) begin
                rd.rd_byte = {2'h0, pdir_r};
            end else if (rd.cur_addr == `UVRA_OFS_PIN_SET) begin
                rd.rd_byte = {2'h0, pout_r};
            end else if (rd.cur_addr == `UVRA_OFS_PIN_LEVEL) begin
                rd.rd_byte = {2'h0, i_pin_levels};
            end
        end else if (rd.blk == `UVRA_BLK_FIFO) begin
            if (rd.cur_addr == `UVRA_OFS_FIFO_GATE) begin
                rd.rd_byte = {6'h00, rxf_on_r, txf_on_r};
            end
        end
    end

    // start of a read run
    assign rd.start = (kind == UVRA_REQ_READ) && !rd.busy;
    assign rd.len = i_length;
    assign rd.first_addr = i_index[7:0];
    assign rd.blk = rblk_r;

    uvra_stream u_stream (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .rd(rd),
        .i_rd_ready(i_rd_ready),
        .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data)
    );

    // outputs straight from the registers
    assign o_ack = ack_r;
    assign o_stall = stall_r;
    assign o_tx_enable = tx_en_r;
    assign o_rx_enable = rx_en_r;
    assign o_baud_divisor = div_r;
    assign o_transmit_bit_mask = txm_r;
    assign o_receive_bit_mask = rxm_r;
    assign o_frame_format = frame_r;
    assign o_pacing_mode = pace_r;
    assign o_resume_character = resume_r;
    assign o_pause_character = pause_r;
    assign o_break_start = brk_go_r;
    assign o_break_duration = brk_r;
    assign o_release_delay = rel_r;
    assign o_pin_mode = pmode_r;
    assign o_pin_direction = pdir_r;
    assign o_pin_output = pout_r;
    assign o_tx_fifo_on = txf_on_r;
    assign o_rx_fifo_on = rxf_on_r;
    assign o_tx_fifo_flush = txf_fl_r;
    assign o_rx_fifo_flush = rxf_fl_r;
endmodule : uvra_bank

/* bench/uvra_bank_assertions.sv */
// port assertions of the block
`timescale 1ns/1ps
module uvra_bank_assertions (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_setup_valid,
    input wire logic [7:0] i_req_type,
    input wire logic [7:0] i_req_code,
    input wire logic [15:0] i_value,
    input wire logic [15:0] i_index,
    input wire logic [15:0] i_length,
    input wire logic i_rd_ready,
    input wire logic o_ack,
    input wire logic o_stall,
    input wire logic o_rd_valid,
    input wire logic [7:0] o_rd_data,
    input wire logic o_tx_enable,
    input wire logic o_rx_enable,
    input wire logic [18:0] o_baud_divisor,
    input wire logic o_break_start,
    input wire logic [15:0] o_break_duration,
    input wire logic o_tx_fifo_on,
    input wire logic o_rx_fifo_on,
    input wire logic o_rx_fifo_flush
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    logic vwr, vbrk, vrd;
    // request kinds
    assign vwr = i_setup_valid && i_req_type == 8'h40 && i_req_code == 8'h00;
    assign vbrk = i_setup_valid && i_req_type == 8'h21 && i_req_code == 8'h23;
    assign vrd = i_setup_valid && i_req_type == 8'hC0 && i_req_code == 8'h01;

    resp_once_a: assert property (i_setup_valid |=> o_ack ^ o_stall)
        else $error("no single answer");
    resp_cause_a: assert property ((o_ack || o_stall) |-> $past(i_setup_valid))
        else $error("stray answer");
    chan_en_a: assert property (o_ack && $past(vwr && i_index == 16'h0003) |->
        {o_rx_enable, o_tx_enable} == $past(i_value[1:0])) else $error("enable wrong");
    div_low_a: assert property (o_ack && $past(vwr && i_index == 16'h0004) |->
        o_baud_divisor[7:0] == $past(i_value[7:0])) else $error("divisor wrong");
    wr_len_a: assert property (vwr && i_length != 16'h0000 |=> o_stall)
        else $error("long write taken");
    brk_ok_a: assert property (o_ack && $past(vbrk) |->
        o_break_start && o_break_duration == $past(i_value)) else $error("break not started");
    brk_bad_a: assert property (vbrk && !(i_index inside {16'h0000, 16'h0002, 16'h0004,
        16'h0006}) |=> o_stall && !o_break_start) else $error("bad break taken");
    rsv_blk_a: assert property (vwr && i_index[15:8] inside {[8'h01:8'h03]} |=>
        $stable(o_baud_divisor) && $stable(o_tx_enable)) else $error("reserved block changed");
    fifo_gate_a: assert property (o_ack && $past(vwr && i_index == 16'h0410) |->
        {o_rx_fifo_on, o_tx_fifo_on} == $past(i_value[1:0])) else $error("fifo gate wrong");
    rx_flush_a: assert property (o_rx_fifo_flush |->
        o_ack && $past(vwr && i_index == 16'h0418 && i_value[7:0] != 8'h00))
        else $error("stray flush");
    rd_start_a: assert property (o_ack && $past(vrd && |i_length) |=> o_rd_valid)
        else $error("no read run");
    rd_hold_a: assert property (o_rd_valid && !i_rd_ready |=>
        o_rd_valid && $stable(o_rd_data)) else $error("read byte not held");
endmodule : uvra_bank_assertions

bind uvra_bank uvra_bank_assertions uvra_bank_assertions_inst (.i_clk, .i_arst_n,
    .i_setup_valid, .i_req_type, .i_req_code, .i_value, .i_index, .i_length, .i_rd_ready,
    .o_ack, .o_stall, .o_rd_valid, .o_rd_data, .o_tx_enable, .o_rx_enable, .o_baud_divisor,
    .o_break_start, .o_break_duration, .o_tx_fifo_on, .o_rx_fifo_on, .o_rx_fifo_flush);

/* bench/uvra_host_model.sv */
// host side of the data stage
`timescale 1ns/1ps
module uvra_host_model (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_slow,
    output logic o_rd_ready
);
    logic [1:0] cnt_r;
    // slow mode takes one cycle in four
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_r <= 2'h0;
            o_rd_ready <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
            o_rd_ready <= !i_slow || (cnt_r == 2'h3);
        end
    end
endmodule : uvra_host_model

/* bench/tb.sv */
// bench for the register access block
`timescale 1ns/1ps
module tb;
    logic clk, rst_n, sv, slow, rdy, ack, stall, rv, txe, rxe, brk, tfo, rfo, tff, rff;
    logic [7:0] rt, rc, rd, ff, rch, pch, fq;
    logic [15:0] val, idx, len, txm, rxm, bdur;
    logic [4:0] errs;
    logic [5:0] pins, pdir, pout;
    logic [18:0] div;
    logic [3:0] pace, rel, pmode;
    logic [7:0] sh [0:255] = '{default: 8'h00};
    logic [31:0] seed = 32'hA914, r;
    logic [1:0] rq [$];
    logic [7:0] dq [$];
    int errors, check_count, nbrk, nrf, ntf, brk_n, rf_n, tf_n;

    uvra_bank uvra_bank_inst (.i_clk(clk), .i_arst_n(rst_n), .i_setup_valid(sv), .i_req_type(rt),
        .i_req_code(rc), .i_value(val), .i_index(idx), .i_length(len), .o_ack(ack), .o_stall(stall),
        .i_rd_ready(rdy), .o_rd_valid(rv), .o_rd_data(rd), .i_line_errors(errs), .i_pin_levels(pins),
        .o_tx_enable(txe), .o_rx_enable(rxe), .o_baud_divisor(div), .o_transmit_bit_mask(txm),
        .o_receive_bit_mask(rxm), .o_frame_format(ff), .o_pacing_mode(pace),
        .o_resume_character(rch), .o_pause_character(pch), .o_break_start(brk),
        .o_break_duration(bdur), .o_release_delay(rel), .o_pin_mode(pmode), .o_pin_direction(pdir),
        .o_pin_output(pout), .o_tx_fifo_on(tfo), .o_rx_fifo_on(rfo), .o_tx_fifo_flush(tff),
        .o_rx_fifo_flush(rff));
    uvra_host_model uvra_host_model_inst (.i_clk(clk), .i_arst_n(rst_n), .i_slow(slow),
        .o_rd_ready(rdy));

    // xorshift source
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // expected read byte
    function logic [7:0] ex(input logic [7:0] b, input logic [7:0] a);
        if (b != 8'h00) return (b == 8'h04 && a == 8'h10) ? fq : 8'h00;
        if (a == 8'h13) return {errs, 3'h0};
        if (a == 8'h1F) return {2'h0, pins};
        return sh[a];
    endfunction : ex

    task chk(input logic [63:0] g, input logic [63:0] e);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask : chk

    task stop_test;
        $display("errors=%0d check_count=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    // one setup packet, e = expected {stall, ack}
    task su(input logic [7:0] t, c, input logic [15:0] v, ix, ln, input logic [1:0] e);
        @(posedge clk);
        {sv, rt, rc, val, idx, len} <= {1'b1, t, c, v, ix, ln};
        rq.push_back(e);
        @(posedge clk);
        {sv, val, idx} <= {1'b0, rnd()}; // idle fields wander
        #1;
    endtask : su

    // one register write; shadow keeps stored bits
    task wr(input logic [7:0] b, a, v);
        logic [7:0] m;
        case (a)
            8'h03: m = 8'h03;
            8'h06: m = 8'h07;
            8'h0C, 8'h15, 8'h1A: m = 8'h0F;
            8'h1B, 8'h1D, 8'h1E: m = 8'h3F;
            8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h10, 8'h11, 8'h14: m = 8'hFF;
            default: m = 8'h00;
        endcase
        su(8'h40, 8'h00, {8'h00, v}, {b, a}, 16'h0000, 2'b01);
        if (b == 8'h00 && a == 8'h1D) sh[a] |= v & m;
        else if (b == 8'h00 && a == 8'h1E) sh[8'h1D] &= ~(v & m);
        else if (b == 8'h00) sh[a] = v & m;
        if (b == 8'h04 && a == 8'h10) fq = v & 8'h03;
        if (b == 8'h00 && a == 8'h14) nbrk++;
        if (b == 8'h04 && a == 8'h18 && v != 8'h00) nrf++;
        if (b == 8'h04 && a == 8'h1C && v != 8'h00) ntf++;
    endtask : wr

    task rdn(input logic [7:0] b, a, input logic [15:0] n);
        for (int k = 0; k < n; k++) dq.push_back(ex(b, a + k[7:0]));
        su(8'hC0, 8'h01, 16'h0000, {b, a}, n, 2'b01);
    endtask : rdn

    task drain;
        for (int w = 0; w < 2000 && dq.size() > 0; w++) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask : drain

    // clock of 8 ns
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // watcher against oldest notes
    always @(posedge clk) begin
        if ((ack | stall) === 1'b1) chk({stall, ack}, rq.size() > 0 ? rq.pop_front() : 2'b00);
        if ((rv & rdy) === 1'b1) chk(rd, dq.size() > 0 ? dq.pop_front() : 9'h100);
        if (brk === 1'b1) brk_n++;
        if (rff === 1'b1) rf_n++;
        if (tff === 1'b1) tf_n++;
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        stop_test();
    end

    initial begin
        {rst_n, sv, slow, rt, rc, val, idx, len, errs, pins, fq} = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        r = rnd();
        errs <= r[4:0];
        pins <= r[13:8];
        @(posedge clk);
        #1;
        chk({div, txm, rxm, txe, rv}, 64'h0);
        for (int a = 0; a < 32; a++) begin
            r = rnd();
            wr(8'h00, a[7:0], r[7:0]);
        end
        chk(div, {sh[8'h06][2:0], sh[8'h05], sh[8'h04]});
        chk({txm, rxm}, {sh[8'h08], sh[8'h07], sh[8'h0A], sh[8'h09]});
        chk({rxe, txe, ff, pace, rch, pch, rel, pmode, pdir, pout}, {sh[8'h03][1:0], sh[8'h0B],
            sh[8'h0C][3:0], sh[8'h10], sh[8'h11], sh[8'h15][3:0], sh[8'h1A][3:0],
            sh[8'h1B][5:0], sh[8'h1D][5:0]});
        slow <= 1'b1;
        rdn(8'h00, 8'h00, 16'h0020);
        drain();
        rdn(8'h00, 8'h04, 16'h0003);
        su(8'h40, 8'h00, 16'h00AA, 16'h0004, 16'h0000, 2'b10);
        drain();
        chk(div[7:0], sh[8'h04]);
        slow <= 1'b0;
        rdn(8'h00, 8'hFE, 16'h0004);
        drain();
        for (int b = 1; b < 6; b++) begin
            wr(b[7:0], 8'h04, 8'h5A);
            rdn(b[7:0], 8'h03, 16'h0002);
            drain();
        end
        chk(div[7:0], sh[8'h04]);
        wr(8'h04, 8'h10, 8'h01);
        chk({rfo, tfo}, 2'b01);
        wr(8'h00, 8'h03, 8'h03);
        wr(8'h04, 8'h10, 8'h03);
        chk({rfo, tfo, txe, rxe}, 4'hF);
        rdn(8'h04, 8'h10, 16'h0001);
        drain();
        wr(8'h04, 8'h18, 8'h01);
        wr(8'h04, 8'h18, 8'h00);
        wr(8'h04, 8'h1C, 8'h80);
        wr(8'h04, 8'h1C, 8'h00);
        for (int k = 0; k < 8; k += 2) begin
            r = rnd();
            su(8'h21, 8'h23, r[15:0], k[15:0], 16'h0000, 2'b01);
            nbrk++;
            chk(bdur, r[15:0]);
        end
        su(8'h21, 8'h23, 16'h0010, 16'h0001, 16'h0000, 2'b10);
        su(8'h21, 8'h23, 16'h0010, 16'h0000, 16'h0001, 2'b10);
        su(8'h40, 8'h00, 16'h0011, 16'h0004, 16'h0001, 2'b10);
        su(8'h40, 8'h07, 16'h0011, 16'h0004, 16'h0000, 2'b10);
        su(8'hC0, 8'h01, 16'h0000, 16'h0004, 16'h0000, 2'b01);
        repeat (3) @(posedge clk);
        chk({brk_n, rf_n}, {nbrk, nrf});
        chk(tf_n, ntf);
        chk(rq.size() + dq.size(), 0);
        stop_test();
    end
endmodule : tb
